/* File: design/sssx_pkg.sv */
// shared offsets, field positions, reset values, opcodes and helpers of the execution block
`default_nettype none
package sssx_pkg;
	localparam int SSSX_AW = 8;
	localparam logic [7:0] OFF_CMD = 8'h00;
	localparam logic [7:0] OFF_SRC_A = 8'h04;
	localparam logic [7:0] OFF_SRC_B = 8'h08;
	localparam logic [7:0] OFF_DEST = 8'h0C;
	localparam logic [7:0] OFF_IMM = 8'h10;
	localparam logic [7:0] OFF_MSW = 8'h14;
	localparam logic [7:0] OFF_PC = 8'h18;
	localparam logic [7:0] OFF_STATUS = 8'h1C;
	localparam logic [7:0] OFF_ST_ADDR = 8'h20;
	localparam logic [7:0] OFF_ST_DATA = 8'h24;
	// machine_state_word bit positions
	localparam int MSW_CARRY = 0;
	localparam int MSW_IRQ = 1;
	localparam int MSW_DC_EN = 2;
	localparam int MSW_IC_EN = 3;
	// status bit positions
	localparam int ST_SLOT = 0;
	localparam int ST_PFX = 1;
	localparam int ST_DC_REFUSED = 2;
	localparam int ST_IC_REFUSED = 3;
	// tag bits, counted from the lsb (msb-first bits 30 and 31)
	localparam int TAG_VALID_BIT = 1;
	localparam int TAG_LOCK_BIT = 0;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [15:0] RST_HALF = 16'h0000;
	localparam logic [3:0] RST_MSW = 4'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_HALF = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;
	typedef enum logic [4:0] {
		OP_NOP = 5'h00, OP_RET_IRQ = 5'h01, OP_RET_CALL = 5'h02,
		OP_STB_REG = 5'h03, OP_STB_IMM = 5'h04, OP_STH_REG = 5'h05, OP_STH_IMM = 5'h06,
		OP_STW_REG = 5'h07, OP_STW_IMM = 5'h08, OP_WIDEN_H = 5'h09, OP_WIDEN_B = 5'h0A,
		OP_SHR_SIGNED = 5'h0B, OP_SHR_CARRY = 5'h0C, OP_SHR_ZERO = 5'h0D,
		OP_LOAD_DLINE = 5'h0E, OP_LOAD_ILINE = 5'h0F, OP_XOR = 5'h10,
		OP_XOR_CONST = 5'h11, OP_IMM_PFX = 5'h12
	} sssx_op_t;
	typedef enum logic [0:0] {SEQ_RUN = 1'b0, SEQ_SLOT = 1'b1} sssx_seq_t;
	// inline constant widening: prefix supplies the upper half when present
	function automatic logic [31:0] sssx_ext_imm(input logic [15:0] imm, input logic pfx_valid,
			input logic [15:0] pfx, input logic zero_ext);
		logic [15:0] upper;
		upper = zero_ext ? 16'h0000 : {16{imm[15]}};
		return pfx_valid ? {pfx, imm} : {upper, imm};
	endfunction
	// byte-strobe merge of a bus write into a word
	function automatic logic [31:0] sssx_merge(input logic [31:0] cur, input logic [31:0] wd,
			input logic [3:0] strb);
		logic [31:0] res;
		res = cur;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return res;
	endfunction
endpackage
`default_nettype wire

/* File: design/sssx_alu.sv */
// register result and carry of widen, shift and exclusive-or operations
`default_nettype none
module sssx_alu
	import sssx_pkg::*;
(
	input wire sssx_op_t op_in,
	input wire logic [31:0] src_a_in,
	input wire logic [31:0] src_b_in,
	input wire logic [31:0] imm_ext_in,
	input wire logic carry_in,
	output logic [31:0] result_out,
	output logic carry_next_out,
	output logic wr_dest_out,
	output logic wr_carry_out
);
	always_comb begin
		result_out = src_a_in;
		carry_next_out = carry_in;
		wr_dest_out = 1'b1;
		wr_carry_out = 1'b0;
		case (op_in)
			OP_WIDEN_H: result_out = {{16{src_a_in[15]}}, src_a_in[15:0]};
			OP_WIDEN_B: result_out = {{24{src_a_in[7]}}, src_a_in[7:0]};
			OP_SHR_SIGNED: begin
				result_out = {src_a_in[31], src_a_in[31:1]};
				carry_next_out = src_a_in[0];
				wr_carry_out = 1'b1;
			end
			OP_SHR_CARRY: begin
				result_out = {carry_in, src_a_in[31:1]};
				carry_next_out = src_a_in[0];
				wr_carry_out = 1'b1;
			end
			OP_SHR_ZERO: begin
				result_out = {1'b0, src_a_in[31:1]};
				carry_next_out = src_a_in[0];
				wr_carry_out = 1'b1;
			end
			OP_XOR: result_out = src_a_in ^ src_b_in;
			OP_XOR_CONST: result_out = src_a_in ^ imm_ext_in;
			default: wr_dest_out = 1'b0;
		endcase
	end
endmodule // sssx_alu
`default_nettype wire

/* File: design/sssx_agu.sv */
// address sum, alignment and store data of stores and returns
`default_nettype none
module sssx_agu
	import sssx_pkg::*;
(
	input wire sssx_op_t op_in,
	input wire logic [31:0] src_a_in,
	input wire logic [31:0] src_b_in,
	input wire logic [31:0] imm_ext_in,
	input wire logic [31:0] dest_in,
	output logic [31:0] sum_out,
	output logic [31:0] addr_out,
	output logic [31:0] data_out,
	output logic [1:0] size_out,
	output logic is_store_out
);
	logic reg_form;
	assign reg_form = (op_in == OP_STB_REG) || (op_in == OP_STH_REG) || (op_in == OP_STW_REG);
	assign sum_out = src_a_in + (reg_form ? src_b_in : imm_ext_in);
	always_comb begin
		addr_out = sum_out;
		data_out = {24'h000000, dest_in[7:0]};
		size_out = SIZE_BYTE;
		is_store_out = 1'b1;
		case (op_in)
			OP_STB_REG, OP_STB_IMM: size_out = SIZE_BYTE;
			OP_STH_REG, OP_STH_IMM: begin
				addr_out = {sum_out[31:1], 1'b0};
				data_out = {16'h0000, dest_in[15:0]};
				size_out = SIZE_HALF;
			end
			OP_STW_REG, OP_STW_IMM: begin
				addr_out = {sum_out[31:2], 2'b00};
				data_out = dest_in;
				size_out = SIZE_WORD;
			end
			default: is_store_out = 1'b0;
		endcase
	end
endmodule // sssx_agu
`default_nettype wire

/* File: design/sssx_exec_top.sv */
// execution block for returns, stores, widening, right shifts, cache line writes and xor, on AXI4-Lite
`default_nettype none
// What this block does
// - return_from_irq jumps to source plus extended constant, then sets irq_allow_flag.
// - the instruction after return_from_irq runs first, with interrupts held off.
// - return_from_call jumps to source plus sign-extended constant, flags untouched.
// - the instruction after return_from_call completes before the jump takes effect.
// - byte stores write the least significant byte of dest_reg.
// - offset stores add source and extended constant; register stores add both sources.
// - halfword stores clear the lowest address bit and write the low halfword.
// - word stores clear the two lowest address bits and write the whole word.
// - widen_half_signed copies the halfword sign bit over the upper sixteen bits.
// - widen_byte_signed copies the byte sign bit over the upper twenty-four bits.
// - signed right shift keeps the sign bit, shifted-out bit goes to carry.
// - right shift through carry inserts old carry, shifted-out bit goes to carry.
// - zero-fill right shift inserts zero, shifted-out bit goes to carry.
// - data cache line write takes tag from first source, data from second.
// - data cache line write happens only while the data cache is disabled.
// - instruction cache line write takes tag from first source, data from second.
// - instruction cache line write happens only while the instruction cache is disabled.
// - register xor writes first source xor second source to dest_reg.
// - xor with constant zero-extends the sixteen-bit constant unless a prefix instruction supplies the upper half.
// - inline constants other than the xor constant sign-extend unless a prefix instruction supplies the upper half.
module sssx_exec_top
	import sssx_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic resetn_in,
	input wire logic [SSSX_AW-1:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [SSSX_AW-1:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	output logic mem_wr_out,
	output logic [31:0] mem_addr_out,
	output logic [31:0] mem_data_out,
	output logic [1:0] mem_size_out,
	output logic dcache_wr_out,
	output logic icache_wr_out,
	output logic [31:0] cache_tag_out,
	output logic [31:0] cache_data_out,
	output logic cache_valid_out,
	output logic cache_lock_out,
	output logic [31:0] pc_out,
	output logic pc_load_out,
	output logic irq_allow_out,
	output logic carry_out
);
	// bus side storage
	logic aw_held, w_held, bvalid, rvalid;
	logic [SSSX_AW-1:0] aw_addr;
	logic [31:0] w_data, rdata;
	logic [3:0] w_strb;
	logic [1:0] bresp, rresp;
	// software visible state
	logic [31:0] first_source_reg, second_source_reg, dest_reg, branch_target, pc;
	logic [15:0] imm_field, pfx_hi;
	logic [3:0] machine_state_word;
	sssx_op_t cmd_op;
	sssx_seq_t seq;
	logic exec_go, ret_irq_pend, pfx_valid, dc_refused, ic_refused;
	// write decode
	logic wr_fire, wr_cmd, wr_a, wr_b, wr_dest, wr_imm, wr_msw, wr_known;
	assign wr_fire = aw_held & w_held & ~bvalid;
	assign wr_cmd = wr_fire & (aw_addr == OFF_CMD);
	assign wr_a = wr_fire & (aw_addr == OFF_SRC_A);
	assign wr_b = wr_fire & (aw_addr == OFF_SRC_B);
	assign wr_dest = wr_fire & (aw_addr == OFF_DEST);
	assign wr_imm = wr_fire & (aw_addr == OFF_IMM);
	assign wr_msw = wr_fire & (aw_addr == OFF_MSW);
	assign wr_known = wr_cmd | wr_a | wr_b | wr_dest | wr_imm | wr_msw;
	assign s_axi_awready_out = ~aw_held & ~bvalid;
	assign s_axi_wready_out = ~w_held & ~bvalid;
	assign s_axi_bvalid_out = bvalid;
	assign s_axi_bresp_out = bresp;
	assign s_axi_arready_out = ~rvalid;
	assign s_axi_rvalid_out = rvalid;
	assign s_axi_rdata_out = rdata;
	assign s_axi_rresp_out = rresp;
	// execute decode
	logic exec_ret, exec_slot, exec_dline, exec_iline, zero_ext;
	logic alu_carry, alu_wr_dest, alu_wr_carry, agu_store;
	logic [31:0] imm_ext, alu_result, agu_sum, agu_addr, agu_data, next_dest, merged_word, imm_merged;
	logic [1:0] agu_size;
	assign exec_ret = exec_go & ((cmd_op == OP_RET_IRQ) | (cmd_op == OP_RET_CALL));
	assign exec_slot = exec_go & (seq == SEQ_SLOT);
	assign exec_dline = exec_go & (cmd_op == OP_LOAD_DLINE);
	assign exec_iline = exec_go & (cmd_op == OP_LOAD_ILINE);
	assign zero_ext = (cmd_op == OP_XOR_CONST);
	assign imm_ext = sssx_ext_imm(imm_field, pfx_valid, pfx_hi, zero_ext);
	assign merged_word = sssx_merge(RST_WORD, w_data, w_strb);
	assign imm_merged = sssx_merge({16'h0000, imm_field}, w_data, w_strb);
	assign next_dest = wr_dest ? sssx_merge(dest_reg, w_data, w_strb) : alu_result;

	sssx_alu u_alu (
		.op_in(cmd_op),
		.src_a_in(first_source_reg),
		.src_b_in(second_source_reg),
		.imm_ext_in(imm_ext),
		.carry_in(machine_state_word[MSW_CARRY]),
		.result_out(alu_result),
		.carry_next_out(alu_carry),
		.wr_dest_out(alu_wr_dest),
		.wr_carry_out(alu_wr_carry)
	);

	sssx_agu u_agu (
		.op_in(cmd_op),
		.src_a_in(first_source_reg),
		.src_b_in(second_source_reg),
		.imm_ext_in(imm_ext),
		.dest_in(dest_reg),
		.sum_out(agu_sum),
		.addr_out(agu_addr),
		.data_out(agu_data),
		.size_out(agu_size),
		.is_store_out(agu_store)
	);

	// read decode
	logic [31:0] rd_word;
	logic rd_known;
	always_comb begin
		rd_word = RST_WORD;
		rd_known = 1'b1;
		case (s_axi_araddr_in)
			OFF_CMD: rd_word = {27'h0000000, cmd_op};
			OFF_SRC_A: rd_word = first_source_reg;
			OFF_SRC_B: rd_word = second_source_reg;
			OFF_DEST: rd_word = dest_reg;
			OFF_IMM: rd_word = {16'h0000, imm_field};
			OFF_MSW: rd_word = {28'h0000000, machine_state_word};
			OFF_PC: rd_word = pc;
			OFF_STATUS: rd_word = {28'h0000000, ic_refused, dc_refused, pfx_valid, seq == SEQ_SLOT};
			OFF_ST_ADDR: rd_word = mem_addr_out;
			OFF_ST_DATA: rd_word = mem_data_out;
			default: rd_known = 1'b0;
		endcase
	end

	// write address and data are taken in either order
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			aw_held <= 1'b0;
			aw_addr <= '0;
		end else if (s_axi_awvalid_in && s_axi_awready_out) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr_in;
		end else if (wr_fire) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			w_held <= 1'b0;
			w_data <= RST_WORD;
			w_strb <= 4'h0;
		end else if (s_axi_wvalid_in && s_axi_wready_out) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata_in;
			w_strb <= s_axi_wstrb_in;
		end else if (wr_fire) begin
			w_held <= 1'b0;
		end
	end

	// write response
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid <= 1'b1;
			bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready_in) begin
			bvalid <= 1'b0;
		end
	end

	// read channel
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rvalid <= 1'b0;
			rdata <= RST_WORD;
			rresp <= RESP_OKAY;
		end else if (s_axi_arvalid_in && !rvalid) begin
			rvalid <= 1'b1;
			rdata <= rd_word;
			rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready_in) begin
			rvalid <= 1'b0;
		end
	end

	// operand registers
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			first_source_reg <= RST_WORD;
			second_source_reg <= RST_WORD;
			imm_field <= RST_HALF;
		end else begin
			if (wr_a) begin
				first_source_reg <= sssx_merge(first_source_reg, w_data, w_strb);
			end
			if (wr_b) begin
				second_source_reg <= sssx_merge(second_source_reg, w_data, w_strb);
			end
			if (wr_imm) begin
				imm_field <= imm_merged[15:0];
			end
		end
	end

	// dest_reg takes software writes and register results
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			dest_reg <= RST_WORD;
		end else if (wr_dest || (exec_go && alu_wr_dest)) begin
			dest_reg <= next_dest;
		end
	end

	// command register starts one execution per write
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cmd_op <= OP_NOP;
			exec_go <= 1'b0;
		end else begin
			exec_go <= wr_cmd;
			if (wr_cmd) begin
				cmd_op <= sssx_op_t'(merged_word[4:0]);
			end
		end
	end

	// machine_state_word: hardware updates win over software writes
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			machine_state_word <= RST_MSW;
		end else begin
			if (wr_msw && w_strb[0]) begin
				machine_state_word <= w_data[3:0];
			end
			if (exec_go && alu_wr_carry) begin
				machine_state_word[MSW_CARRY] <= alu_carry;
			end
			if (exec_slot && ret_irq_pend) begin
				machine_state_word[MSW_IRQ] <= 1'b1;
			end
		end
	end

	// delay slot sequencing of returns
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			seq <= SEQ_RUN;
			ret_irq_pend <= 1'b0;
			branch_target <= RST_WORD;
			pc <= RST_WORD;
			pc_load_out <= 1'b0;
		end else begin
			pc_load_out <= exec_slot;
			if (exec_slot) begin
				pc <= branch_target;
				seq <= SEQ_RUN;
				ret_irq_pend <= 1'b0;
			end
			if (exec_ret) begin
				branch_target <= agu_sum;
				seq <= SEQ_SLOT;
				ret_irq_pend <= (cmd_op == OP_RET_IRQ);
			end
		end
	end

	// interrupts stay off while a delay slot is outstanding
	assign irq_allow_out = machine_state_word[MSW_IRQ] & (seq == SEQ_RUN);
	assign carry_out = machine_state_word[MSW_CARRY];
	assign pc_out = pc;

	// immediate prefix applies to the next executed instruction only
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			pfx_valid <= 1'b0;
			pfx_hi <= RST_HALF;
		end else if (exec_go) begin
			pfx_valid <= (cmd_op == OP_IMM_PFX);
			if (cmd_op == OP_IMM_PFX) begin
				pfx_hi <= imm_field;
			end
		end
	end

	// memory store port
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			mem_wr_out <= 1'b0;
			mem_addr_out <= RST_WORD;
			mem_data_out <= RST_WORD;
			mem_size_out <= SIZE_BYTE;
		end else begin
			mem_wr_out <= exec_go & agu_store;
			if (exec_go && agu_store) begin
				mem_addr_out <= agu_addr;
				mem_data_out <= agu_data;
				mem_size_out <= agu_size;
			end
		end
	end

	// cache line writes, refused while the matching cache is enabled
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			dcache_wr_out <= 1'b0;
			icache_wr_out <= 1'b0;
			dc_refused <= 1'b0;
			ic_refused <= 1'b0;
		end else begin
			dcache_wr_out <= exec_dline & ~machine_state_word[MSW_DC_EN];
			icache_wr_out <= exec_iline & ~machine_state_word[MSW_IC_EN];
			if (exec_dline) begin
				dc_refused <= machine_state_word[MSW_DC_EN];
			end
			if (exec_iline) begin
				ic_refused <= machine_state_word[MSW_IC_EN];
			end
		end
	end

	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cache_tag_out <= RST_WORD;
			cache_data_out <= RST_WORD;
			cache_valid_out <= 1'b0;
			cache_lock_out <= 1'b0;
		end else if ((exec_dline && !machine_state_word[MSW_DC_EN])
				|| (exec_iline && !machine_state_word[MSW_IC_EN])) begin
			cache_tag_out <= first_source_reg;
			cache_data_out <= second_source_reg;
			cache_valid_out <= first_source_reg[TAG_VALID_BIT];
			cache_lock_out <= first_source_reg[TAG_LOCK_BIT];
		end
	end
endmodule // sssx_exec_top
`default_nettype wire

/* File: verification/sssx_exec_props.sv */
// concurrent checks on the ports of the execution block
`default_nettype none
module sssx_exec_props
	import sssx_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic resetn_in,
	input wire logic s_axi_awvalid_in,
	input wire logic s_axi_awready_out,
	input wire logic s_axi_wvalid_in,
	input wire logic s_axi_wready_out,
	input wire logic s_axi_bvalid_out,
	input wire logic s_axi_arvalid_in,
	input wire logic s_axi_arready_out,
	input wire logic s_axi_rvalid_out,
	input wire logic mem_wr_out,
	input wire logic [31:0] mem_addr_out,
	input wire logic [31:0] mem_data_out,
	input wire logic [1:0] mem_size_out,
	input wire logic dcache_wr_out,
	input wire logic icache_wr_out,
	input wire logic [31:0] cache_tag_out,
	input wire logic cache_valid_out,
	input wire logic cache_lock_out,
	input wire logic [31:0] pc_out,
	input wire logic pc_load_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!resetn_in);
	sequence s_both_taken;
		s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
	endsequence
	// an execution result shows one cycle after the write response rose
	sequence s_exec_edge;
		$past(s_axi_bvalid_out) && !$past(s_axi_bvalid_out, 2);
	endsequence
	a_write_answer: assert property (s_both_taken |-> ##2 s_axi_bvalid_out)
		else $error("write response not on time");
	a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
		else $error("read data not on time");
	a_busy_refuse: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
		else $error("write taken while response pending");
	a_read_refuse: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
		else $error("read taken while data pending");
	a_store_exec: assert property (mem_wr_out |-> s_exec_edge)
		else $error("store pulse apart from execution");
	a_byte_store: assert property (mem_wr_out && mem_size_out == SIZE_BYTE |-> mem_data_out[31:8] == 24'h000000)
		else $error("byte store carries upper bits");
	a_half_store: assert property (mem_wr_out && mem_size_out == SIZE_HALF |-> !mem_addr_out[0] && mem_data_out[31:16] == 16'h0000)
		else $error("halfword store misaligned or wide");
	a_word_store: assert property (mem_wr_out && mem_size_out == SIZE_WORD |-> mem_addr_out[1:0] == 2'h0)
		else $error("word store misaligned");
	a_cache_flags: assert property (dcache_wr_out || icache_wr_out |-> cache_valid_out == cache_tag_out[1] && cache_lock_out == cache_tag_out[0])
		else $error("cache valid or lock not from tag");
	a_cache_pulse: assert property (dcache_wr_out || icache_wr_out |-> s_exec_edge ##1 !(dcache_wr_out || icache_wr_out))
		else $error("cache write pulse malformed");
	a_one_effect: assert property ($onehot0({mem_wr_out, dcache_wr_out, icache_wr_out}))
		else $error("two effects in one cycle");
	a_pc_hold: assert property (!pc_load_out |-> $stable(pc_out))
		else $error("pc moved without load");
	a_jump_exec: assert property (pc_load_out |-> s_exec_edge)
		else $error("jump apart from slot execution");
endmodule // sssx_exec_props
bind sssx_exec_top sssx_exec_props sssx_exec_props_inst (.*);
`default_nettype wire

/* File: verification/sssx_tb.sv */
// self-checking bench of the execution block
`default_nettype none
module tb
	import sssx_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [66:0] v; logic [66:0] m;} sssx_exp_t;
	localparam logic [66:0] full_m = {67{1'b1}};
	logic core_clk_in = 1'b0, resetn_in = 1'b0;
	logic [SSSX_AW-1:0] s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
	logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_arvalid_in = 1'b0;
	logic s_axi_bready_in = 1'b1, s_axi_rready_in = 1'b1;
	logic [31:0] s_axi_wdata_in = 32'h0;
	logic [3:0] s_axi_wstrb_in = 4'hF;
	logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
	logic [1:0] s_axi_bresp_out, s_axi_rresp_out, mem_size_out;
	logic [31:0] s_axi_rdata_out, mem_addr_out, mem_data_out, cache_tag_out, cache_data_out, pc_out;
	logic mem_wr_out, dcache_wr_out, icache_wr_out, cache_valid_out, cache_lock_out;
	logic pc_load_out, irq_allow_out, carry_out;
	sssx_exp_t rd_q[$], b_q[$], mem_q[$], ca_q[$], pc_q[$];
	int err_count = 0, compares = 0;
	logic [31:0] lfsr = 32'h000005CE, va, vb, rd, re;
	logic [15:0] im;
	logic [3:0] msw = 4'h0;
	sssx_exec_top sssx_exec_top_inst (.*);
	always #20 core_clk_in = ~core_clk_in;
	function automatic logic [31:0] rnd();
		repeat (17) lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction
	task automatic cmp(input string n, input logic [66:0] e, input logic [66:0] g, input logic [66:0] m);
		compares++;
		if ((e & m) !== (g & m)) begin
			err_count++;
			$display("BAD %s expected %h seen %h", n, e & m, g & m);
		end
	endtask
	task automatic match(input string n, ref sssx_exp_t q[$], input logic [66:0] g);
		sssx_exp_t e;
		if (q.size() == 0) begin
			err_count++;
			$display("BAD %s expected none seen %h", n, g);
		end else begin
			e = q.pop_front();
			cmp(n, e.v, g, e.m);
		end
	endtask
	// second process: outputs against the oldest note
	always @(posedge core_clk_in) begin
		if (s_axi_rvalid_out) match("read", rd_q, {33'h0, s_axi_rresp_out, s_axi_rdata_out});
		if (s_axi_bvalid_out) match("bresp", b_q, {65'h0, s_axi_bresp_out});
		if (mem_wr_out) match("store", mem_q, {1'b0, mem_addr_out, mem_data_out, mem_size_out});
		if (dcache_wr_out || icache_wr_out) match("cache", ca_q,
			{icache_wr_out, cache_tag_out, cache_data_out, cache_valid_out, cache_lock_out});
		if (pc_load_out) match("pc", pc_q, {35'h0, pc_out});
	end
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic aw_done, w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		b_q.push_back({65'h0, r, full_m});
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= d;
		s_axi_awvalid_in <= 1'b1;
		s_axi_wvalid_in <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge core_clk_in);
			aw_done |= s_axi_awvalid_in && s_axi_awready_out;
			w_done |= s_axi_wvalid_in && s_axi_wready_out;
			s_axi_awvalid_in <= !aw_done;
			s_axi_wvalid_in <= !w_done;
		end
		do @(posedge core_clk_in); while (!s_axi_bvalid_out);
	endtask
	task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] r);
		rd_q.push_back({33'h0, r, e, 33'h0, 2'h3, m});
		s_axi_araddr_in <= a;
		s_axi_arvalid_in <= 1'b1;
		do @(posedge core_clk_in); while (!s_axi_arready_out);
		s_axi_arvalid_in <= 1'b0;
		do @(posedge core_clk_in); while (!s_axi_rvalid_out);
	endtask
	task automatic run(input logic [4:0] op);
		axi_wr(OFF_CMD, {27'h0, op}, RESP_OKAY);
	endtask
	task automatic wr_msw(input logic [3:0] m);
		msw = m;
		axi_wr(OFF_MSW, {28'h0, m}, RESP_OKAY);
	endtask
	task automatic rd_dest(input logic [31:0] e);
		axi_rd(OFF_DEST, e, 32'hFFFFFFFF, RESP_OKAY);
	endtask
	task automatic set_ops(input logic [31:0] a, input logic [31:0] b, input logic [31:0] d, input logic [15:0] i);
		axi_wr(OFF_SRC_A, a, RESP_OKAY);
		axi_wr(OFF_SRC_B, b, RESP_OKAY);
		axi_wr(OFF_DEST, d, RESP_OKAY);
		axi_wr(OFF_IMM, {16'h0, i}, RESP_OKAY);
	endtask
	task automatic give_verdict();
		if (rd_q.size() + b_q.size() + mem_q.size() + ca_q.size() + pc_q.size() != 0) begin
			err_count++;
			$display("BAD pending notes expected 0 seen %0d", rd_q.size() + b_q.size() + mem_q.size() + ca_q.size() + pc_q.size());
		end
		$display("errors %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge core_clk_in);
		err_count++;
		$display("BAD watchdog expected done seen hang");
		give_verdict();
	end
	initial begin
		repeat (8) @(posedge core_clk_in);
		resetn_in <= 1'b1;
		@(posedge core_clk_in);
		for (int i = 0; i < 10; i++) axi_rd(8'(4 * i), 32'h0, 32'hFFFFFFFF, RESP_OKAY);
		axi_rd(8'h28, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
		axi_wr(8'h2C, rnd(), RESP_SLVERR);
		va = rnd();
		vb = rnd();
		re = rnd();
		im = {1'b1, re[14:0]};
		set_ops(va, vb, rnd(), im);
		run(OP_XOR);
		rd_dest(va ^ vb);
		run(OP_XOR_CONST);
		rd_dest(va ^ {16'h0, im});
		axi_wr(OFF_IMM, {16'h0, re[31:16]}, RESP_OKAY);
		run(OP_IMM_PFX);
		axi_wr(OFF_IMM, {16'h0, im}, RESP_OKAY);
		run(OP_XOR_CONST);
		rd_dest(va ^ {re[31:16], im});
		for (int j = 0; j < 4; j++) begin
			va = rnd();
			va[15] = j[0];
			va[7] = j[0];
			axi_wr(OFF_SRC_A, va, RESP_OKAY);
			run(j[1] ? OP_WIDEN_B : OP_WIDEN_H);
			rd_dest(j[1] ? {{24{va[7]}}, va[7:0]} : {{16{va[15]}}, va[15:0]});
		end
		for (int k = 0; k < 6; k++) begin
			va = rnd();
			wr_msw({3'h0, va[9]});
			axi_wr(OFF_SRC_A, va, RESP_OKAY);
			run(5'(OP_SHR_SIGNED + k % 3));
			rd_dest(k % 3 == 0 ? {va[31], va[31:1]} : k % 3 == 1 ? {msw[0], va[31:1]} : {1'b0, va[31:1]});
			msw[0] = va[0];
			axi_rd(OFF_MSW, {28'h0, msw}, 32'hFFFFFFFF, RESP_OKAY);
			cmp("carry", {66'h0, va[0]}, {66'h0, carry_out}, full_m);
		end
		for (int i = 0; i < 6; i++) begin
			va = rnd();
			vb = rnd();
			rd = rnd();
			re = rnd();
			im = {1'b1, re[14:0]};
			set_ops(va, vb, rd, im);
			re = va + (i % 2 == 0 ? vb : {16'hFFFF, im});
			case (i / 2)
				0: mem_q.push_back({1'b0, re, 24'h0, rd[7:0], SIZE_BYTE, full_m});
				1: mem_q.push_back({1'b0, re[31:1], 1'b0, 16'h0, rd[15:0], SIZE_HALF, full_m});
				default: mem_q.push_back({1'b0, re[31:2], 2'h0, rd, SIZE_WORD, full_m});
			endcase
			run(5'(OP_STB_REG + i));
		end
		wr_msw(4'h0);
		for (int i = 0; i < 2; i++) begin
			va = rnd();
			vb = rnd();
			set_ops(va, vb, 32'h0, 16'h0);
			ca_q.push_back({i[0], va, vb, va[1], va[0], full_m});
			run(i ? OP_LOAD_ILINE : OP_LOAD_DLINE);
			wr_msw(i ? 4'h8 : 4'h4);
			run(i ? OP_LOAD_ILINE : OP_LOAD_DLINE);
			axi_rd(OFF_STATUS, i ? 32'h8 : 32'h4, i ? 32'h8 : 32'h4, RESP_OKAY);
		end
		wr_msw(4'h1);
		va = rnd();
		vb = rnd();
		re = rnd();
		im = {1'b1, re[14:0]};
		set_ops(va, vb, 32'h0, im);
		run(OP_RET_CALL);
		axi_rd(OFF_STATUS, 32'h1, 32'h1, RESP_OKAY);
		axi_rd(OFF_PC, 32'h0, 32'hFFFFFFFF, RESP_OKAY);
		pc_q.push_back({35'h0, va + {16'hFFFF, im}, full_m});
		run(OP_XOR);
		rd_dest(va ^ vb);
		axi_rd(OFF_MSW, 32'h1, 32'hFFFFFFFF, RESP_OKAY);
		for (int t = 0; t < 2; t++) begin
			wr_msw({2'h0, t[0], 1'b0});
			va = rnd();
			axi_wr(OFF_SRC_A, va, RESP_OKAY);
			run(OP_RET_IRQ);
			axi_rd(OFF_MSW, {30'h0, t[0], 1'b0}, 32'h2, RESP_OKAY);
			cmp("irq_allow", 67'h0, {66'h0, irq_allow_out}, full_m);
			pc_q.push_back({35'h0, va + {16'hFFFF, im}, full_m});
			run(OP_NOP);
			axi_rd(OFF_MSW, 32'h2, 32'hFFFFFFFF, RESP_OKAY);
			cmp("irq_allow", 67'h1, {66'h0, irq_allow_out}, full_m);
		end
		repeat (4) @(posedge core_clk_in);
		give_verdict();
	end
endmodule // tb
`default_nettype wire
